// ### pci_sig_pkg.sv
// Shared constants and state types for both ends of the primary PCI link.
// Assumes one 200 MHz clock and one active-low asynchronous reset.
package pci_sig_pkg;

  // ****************************************************************
  // Widths and codes
  // ****************************************************************
  localparam int unsigned AD_W          = 32;
  localparam int unsigned CBE_W         = 4;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned TMR_W         = 3;
  localparam logic [3:0]  CMD_DAC       = 4'hd;
  localparam int unsigned DEC_HI        = 31;
  localparam int unsigned DEC_LO        = 28;
  localparam logic [3:0]  TGT_BASE_DEF  = 4'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DEVSEL_CLKS   = 5;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_ADDR = 3'h2,
    M_DATA = 3'h4
  } mst_state_t;

  typedef enum logic [4:0] {
    T_IDLE = 5'h01,
    T_DAC  = 5'h02,
    T_TURN = 5'h04,
    T_DATA = 5'h08,
    T_SKIP = 5'h10
  } tgt_state_t;

endpackage

// ### pci_bus_if.sv
// Primary PCI wires between the bridge end (initiator) and an agent end (target).
// Assumes both ends are clocked by the same sys_clk; wires resolve here from enables.
`timescale 1ns/1ps
interface pci_bus_if;

  // ****************************************************************
  // Per-party drive
  // ****************************************************************
  logic [31:0] dev_ad;
  logic        dev_ad_oe;
  logic [3:0]  dev_cbe_n;
  logic        dev_cbe_oe;
  logic        dev_par;
  logic        dev_par_oe;
  logic        dev_frame_n;
  logic        dev_frame_oe;
  logic        dev_irdy_n;
  logic        dev_irdy_oe;
  logic [31:0] agt_ad;
  logic        agt_ad_oe;
  logic        agt_par;
  logic        agt_par_oe;
  logic        agt_trdy_n;
  logic        agt_trdy_oe;
  logic        agt_devsel_n;
  logic        agt_devsel_oe;

  // ****************************************************************
  // Resolved wires
  // ****************************************************************
  // Undriven tristate lines read as zero; control lines have pull-ups
  logic [31:0] ad;
  logic [3:0]  cbe_n;
  logic        par;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;
  logic        devsel_n;

  assign ad       = dev_ad_oe ? dev_ad : (agt_ad_oe ? agt_ad : 32'h0000_0000);
  assign cbe_n    = dev_cbe_oe ? dev_cbe_n : 4'h0;
  assign par      = dev_par_oe ? dev_par : (agt_par_oe ? agt_par : 1'b0);
  assign frame_n  = dev_frame_oe ? dev_frame_n : 1'b1;
  assign irdy_n   = dev_irdy_oe ? dev_irdy_n : 1'b1;
  assign trdy_n   = agt_trdy_oe ? agt_trdy_n : 1'b1;
  assign devsel_n = agt_devsel_oe ? agt_devsel_n : 1'b1;

  modport bridge (
    output dev_ad, dev_ad_oe, dev_cbe_n, dev_cbe_oe, dev_par, dev_par_oe,
    output dev_frame_n, dev_frame_oe, dev_irdy_n, dev_irdy_oe,
    input  ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n
  );

  modport agent (
    output agt_ad, agt_ad_oe, agt_par, agt_par_oe,
    output agt_trdy_n, agt_trdy_oe, agt_devsel_n, agt_devsel_oe,
    input  ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n
  );

endinterface

// ### pci_bridge_end.sv
// Bridge primary end: PCI initiator with bus parking and devsel timeout.
// Assumes pci_bus_if.bridge on the link, grant from an outside arbiter,
// and a user that shows wdata/be_n for word_idx in the same cycle.
`timescale 1ns/1ps
module pci_bridge_end #(
  parameter int unsigned DEVSEL_LIMIT = pci_sig_pkg::DEVSEL_CLKS,
  parameter int unsigned CNT_W        = pci_sig_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Link
  pci_bus_if.bridge             bus,
  // Arbiter
  input  wire logic             gnt_n,
  // Request
  input  wire logic             start,
  input  wire logic             wr,
  input  wire logic             dac,
  input  wire logic [3:0]       cmd,
  input  wire logic [31:0]      addr,
  input  wire logic [31:0]      addr_hi,
  input  wire logic [CNT_W-1:0] count,
  output logic                  busy,
  // Data words
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       be_n,
  output logic [CNT_W-1:0]      word_idx,
  output logic [31:0]           rdata,
  output logic                  rvalid,
  // Status
  output logic                  done,
  output logic                  abort,
  output logic                  perr
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [pci_sig_pkg::TMR_W-1:0] TMR_END = DEVSEL_LIMIT[pci_sig_pkg::TMR_W-1:0];

  pci_sig_pkg::mst_state_t    st_q, st_d;
  logic [31:0]                ad_q, ad_d, hi_q, chk_ad_q, rdata_q;
  logic [3:0]                 cbe_q, cbe_d, cmd_q, chk_cbe_q;
  logic                       ad_oe_q, ad_oe_d, cbe_oe_q, cbe_oe_d, par_q, par_oe_q;
  logic                       frame_n_q, frame_oe_q, frame_a_d;
  logic                       irdy_n_q, irdy_oe_q, irdy_a_d;
  logic                       wr_q, dac_q, dac_d, clm_q, clm_d;
  logic [CNT_W-1:0]           cnt_q, cnt_d, idx_q, idx_d;
  logic [pci_sig_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic                       rv_d, rv_q, done_d, done_q, abort_d, abort_q, busy_q;
  logic                       chk_d, chk_q, perr_q, take;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    st_d      = st_q;
    ad_d      = ad_q;
    ad_oe_d   = ad_oe_q;
    cbe_d     = cbe_q;
    cbe_oe_d  = cbe_oe_q;
    frame_a_d = !frame_n_q;
    irdy_a_d  = !irdy_n_q;
    cnt_d     = cnt_q;
    idx_d     = idx_q;
    tmr_d     = tmr_q;
    clm_d     = clm_q;
    dac_d     = dac_q;
    take      = 1'b0;
    rv_d      = 1'b0;
    done_d    = 1'b0;
    abort_d   = 1'b0;
    chk_d     = 1'b0;
    unique case (st_q)
      pci_sig_pkg::M_IDLE: begin
        if (!gnt_n && bus.frame_n && bus.irdy_n) begin
          ad_oe_d  = 1'b1;
          cbe_oe_d = 1'b1;
          if (start) begin
            st_d      = pci_sig_pkg::M_ADDR;
            frame_a_d = 1'b1;
            ad_d      = addr;
            cbe_d     = dac ? pci_sig_pkg::CMD_DAC : cmd;
            dac_d     = dac;
            cnt_d     = count;
            idx_d     = '0;
            tmr_d     = '0;
            clm_d     = 1'b0;
          end
        end else begin
          ad_oe_d  = 1'b0;
          cbe_oe_d = 1'b0;
        end
      end
      pci_sig_pkg::M_ADDR: begin
        tmr_d = tmr_q + 1'b1;
        if (dac_q) begin
          // Second address phase of a dual address cycle
          ad_d  = hi_q;
          cbe_d = cmd_q;
          dac_d = 1'b0;
        end else begin
          st_d      = pci_sig_pkg::M_DATA;
          irdy_a_d  = 1'b1;
          frame_a_d = (cnt_q != CNT_W'(1));
          take      = 1'b1;
          ad_oe_d   = wr_q;
        end
      end
      pci_sig_pkg::M_DATA: begin
        if (tmr_q != TMR_END) begin
          tmr_d = tmr_q + 1'b1;
        end
        if (!bus.devsel_n) begin
          clm_d = 1'b1;
        end
        if (!bus.devsel_n && !bus.trdy_n) begin
          rv_d  = !wr_q;
          chk_d = !wr_q;
          if (cnt_q == CNT_W'(1)) begin
            st_d      = pci_sig_pkg::M_IDLE;
            irdy_a_d  = 1'b0;
            ad_oe_d   = 1'b0;
            cbe_oe_d  = 1'b0;
            done_d    = 1'b1;
          end else begin
            cnt_d     = cnt_q - 1'b1;
            frame_a_d = (cnt_q != CNT_W'(2));
            take      = 1'b1;
          end
        end else if (!clm_q && bus.devsel_n && tmr_q == TMR_END) begin
          // Nobody claimed the cycle in time
          st_d      = pci_sig_pkg::M_IDLE;
          frame_a_d = 1'b0;
          irdy_a_d  = 1'b0;
          ad_oe_d   = 1'b0;
          cbe_oe_d  = 1'b0;
          abort_d   = 1'b1;
        end
      end
    endcase
    if (take) begin
      ad_d  = wdata;
      cbe_d = be_n;
      idx_d = idx_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= pci_sig_pkg::M_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      tmr_q <= '0;
      clm_q <= 1'b0;
      dac_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      clm_q <= clm_d;
      dac_q <= dac_d;
    end
  end

  // Request fields held for the whole transaction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      cmd_q <= 4'h0;
      hi_q  <= 32'h0000_0000;
    end else if (st_q == pci_sig_pkg::M_IDLE && st_d == pci_sig_pkg::M_ADDR) begin
      wr_q  <= wr;
      cmd_q <= cmd;
      hi_q  <= addr_hi;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_q       <= 32'h0000_0000;
      ad_oe_q    <= 1'b0;
      cbe_q      <= 4'hf;
      cbe_oe_q   <= 1'b0;
      frame_n_q  <= 1'b1;
      frame_oe_q <= 1'b0;
      irdy_n_q   <= 1'b1;
      irdy_oe_q  <= 1'b0;
    end else begin
      ad_q       <= ad_d;
      ad_oe_q    <= ad_oe_d;
      cbe_q      <= cbe_d;
      cbe_oe_q   <= cbe_oe_d;
      frame_n_q  <= !frame_a_d;
      frame_oe_q <= frame_a_d || !frame_n_q;
      irdy_n_q   <= !irdy_a_d;
      irdy_oe_q  <= irdy_a_d || !irdy_n_q;
    end
  end

  // Parity trails whatever this end put on ad one clock earlier
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_q    <= 1'b0;
      par_oe_q <= 1'b0;
    end else begin
      par_q    <= ^{ad_q, cbe_q};
      par_oe_q <= ad_oe_q;
    end
  end

  // ****************************************************************
  // Read data and parity check
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_q     <= 1'b0;
      chk_ad_q  <= 32'h0000_0000;
      chk_cbe_q <= 4'h0;
      perr_q    <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rv_q      <= 1'b0;
      done_q    <= 1'b0;
      abort_q   <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      chk_q   <= chk_d;
      rv_q    <= rv_d;
      done_q  <= done_d;
      abort_q <= abort_d;
      busy_q  <= (st_d != pci_sig_pkg::M_IDLE);
      if (chk_d) begin
        chk_ad_q  <= bus.ad;
        chk_cbe_q <= bus.cbe_n;
      end
      if (rv_d) begin
        rdata_q <= bus.ad;
      end
      perr_q <= chk_q && (^{chk_ad_q, chk_cbe_q, bus.par});
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.dev_ad       = ad_q;
  assign bus.dev_ad_oe    = ad_oe_q;
  assign bus.dev_cbe_n    = cbe_q;
  assign bus.dev_cbe_oe   = cbe_oe_q;
  assign bus.dev_par      = par_q;
  assign bus.dev_par_oe   = par_oe_q;
  assign bus.dev_frame_n  = frame_n_q;
  assign bus.dev_frame_oe = frame_oe_q;
  assign bus.dev_irdy_n   = irdy_n_q;
  assign bus.dev_irdy_oe  = irdy_oe_q;
  assign busy             = busy_q;
  assign word_idx         = idx_q;
  assign rdata            = rdata_q;
  assign rvalid           = rv_q;
  assign done             = done_q;
  assign abort            = abort_q;
  assign perr             = perr_q;

endmodule

// ### pci_agent_end.sv
// Far end of the primary link: a PCI target with fast decode.
// Assumes pci_bus_if.agent on the link and a user that shows rdata
// for word_idx in the same cycle.
`timescale 1ns/1ps
module pci_agent_end #(
  parameter logic [3:0]  BASE  = pci_sig_pkg::TGT_BASE_DEF,
  parameter int unsigned CNT_W = pci_sig_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Link
  pci_bus_if.agent              bus,
  // Read data source
  input  wire logic [31:0]      rdata,
  output logic [CNT_W-1:0]      word_idx,
  // Write data sink
  output logic [31:0]           wdata,
  output logic [3:0]            wbe_n,
  output logic                  wvalid,
  // Transaction status
  output logic [31:0]           addr,
  output logic [3:0]            cmd,
  output logic                  perr
);

  // ****************************************************************
  // State
  // ****************************************************************
  pci_sig_pkg::tgt_state_t st_q, st_d;
  logic [31:0]      ad_q, ad_d, addr_q, addr_d, wdata_q, chk_ad_q;
  logic [3:0]       cmd_q, cmd_d, wbe_q, chk_cbe_q;
  logic             ad_oe_q, ad_oe_d, par_q, par_oe_q, wr_q, wr_d, fprev_q;
  logic             trdy_n_q, trdy_oe_q, trdy_a_d, dsel_n_q, dsel_oe_q, dsel_a_d;
  logic             claim, hit, wv_d, wv_q, chk_d, chk_q, perr_q, take;
  logic [CNT_W-1:0] idx_q, idx_d;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    st_d     = st_q;
    ad_d     = ad_q;
    ad_oe_d  = ad_oe_q;
    addr_d   = addr_q;
    cmd_d    = cmd_q;
    wr_d     = wr_q;
    idx_d    = idx_q;
    trdy_a_d = !trdy_n_q;
    dsel_a_d = !dsel_n_q;
    claim    = 1'b0;
    hit      = 1'b0;
    take     = 1'b0;
    wv_d     = 1'b0;
    chk_d    = 1'b0;
    unique case (st_q)
      pci_sig_pkg::T_IDLE: begin
        if (!bus.frame_n && fprev_q) begin
          addr_d = bus.ad;
          cmd_d  = bus.cbe_n;
          chk_d  = 1'b1;
          if (bus.cbe_n == pci_sig_pkg::CMD_DAC) begin
            st_d = pci_sig_pkg::T_DAC;
          end else begin
            claim = 1'b1;
            hit   = (bus.ad[pci_sig_pkg::DEC_HI:pci_sig_pkg::DEC_LO] == BASE);
          end
        end
      end
      pci_sig_pkg::T_DAC: begin
        // Upper address must be zero to fall in our window
        cmd_d = bus.cbe_n;
        chk_d = 1'b1;
        claim = 1'b1;
        hit   = (bus.ad == 32'h0000_0000) &&
                (addr_q[pci_sig_pkg::DEC_HI:pci_sig_pkg::DEC_LO] == BASE);
      end
      pci_sig_pkg::T_TURN: begin
        st_d     = pci_sig_pkg::T_DATA;
        ad_oe_d  = 1'b1;
        trdy_a_d = 1'b1;
        take     = 1'b1;
      end
      pci_sig_pkg::T_DATA: begin
        if (!bus.irdy_n) begin
          wv_d  = wr_q;
          chk_d = wr_q;
          if (bus.frame_n) begin
            st_d     = pci_sig_pkg::T_IDLE;
            trdy_a_d = 1'b0;
            dsel_a_d = 1'b0;
            ad_oe_d  = 1'b0;
          end else begin
            take = !wr_q;
          end
        end
      end
      pci_sig_pkg::T_SKIP: begin
        if (bus.frame_n && bus.irdy_n) begin
          st_d = pci_sig_pkg::T_IDLE;
        end
      end
    endcase
    if (claim) begin
      if (hit) begin
        wr_d     = cmd_d[0];
        dsel_a_d = 1'b1;
        trdy_a_d = cmd_d[0];
        idx_d    = '0;
        st_d     = cmd_d[0] ? pci_sig_pkg::T_DATA : pci_sig_pkg::T_TURN;
      end else begin
        st_d = pci_sig_pkg::T_SKIP;
      end
    end
    if (take) begin
      ad_d  = rdata;
      idx_d = idx_d + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= pci_sig_pkg::T_IDLE;
      addr_q  <= 32'h0000_0000;
      cmd_q   <= 4'h0;
      wr_q    <= 1'b0;
      idx_q   <= '0;
      fprev_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      cmd_q   <= cmd_d;
      wr_q    <= wr_d;
      idx_q   <= idx_d;
      fprev_q <= bus.frame_n && bus.irdy_n;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_q      <= 32'h0000_0000;
      ad_oe_q   <= 1'b0;
      trdy_n_q  <= 1'b1;
      trdy_oe_q <= 1'b0;
      dsel_n_q  <= 1'b1;
      dsel_oe_q <= 1'b0;
      par_q     <= 1'b0;
      par_oe_q  <= 1'b0;
    end else begin
      ad_q      <= ad_d;
      ad_oe_q   <= ad_oe_d;
      trdy_n_q  <= !trdy_a_d;
      trdy_oe_q <= trdy_a_d || !trdy_n_q;
      dsel_n_q  <= !dsel_a_d;
      dsel_oe_q <= dsel_a_d || !dsel_n_q;
      // Byte enables come from the initiator, sampled in the same cycle
      par_q     <= ^{ad_q, bus.cbe_n};
      par_oe_q  <= ad_oe_q;
    end
  end

  // ****************************************************************
  // Write data and parity check
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q   <= 32'h0000_0000;
      wbe_q     <= 4'hf;
      wv_q      <= 1'b0;
      chk_q     <= 1'b0;
      chk_ad_q  <= 32'h0000_0000;
      chk_cbe_q <= 4'h0;
      perr_q    <= 1'b0;
    end else begin
      wv_q  <= wv_d;
      chk_q <= chk_d;
      if (wv_d) begin
        wdata_q <= bus.ad;
        wbe_q   <= bus.cbe_n;
      end
      if (chk_d) begin
        chk_ad_q  <= bus.ad;
        chk_cbe_q <= bus.cbe_n;
      end
      perr_q <= chk_q && (^{chk_ad_q, chk_cbe_q, bus.par});
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.agt_ad        = ad_q;
  assign bus.agt_ad_oe     = ad_oe_q;
  assign bus.agt_par       = par_q;
  assign bus.agt_par_oe    = par_oe_q;
  assign bus.agt_trdy_n    = trdy_n_q;
  assign bus.agt_trdy_oe   = trdy_oe_q;
  assign bus.agt_devsel_n  = dsel_n_q;
  assign bus.agt_devsel_oe = dsel_oe_q;
  assign word_idx          = idx_q;
  assign wdata             = wdata_q;
  assign wbe_n             = wbe_q;
  assign wvalid            = wv_q;
  assign addr              = addr_q;
  assign cmd               = cmd_q;
  assign perr              = perr_q;

endmodule

// ### pci_sig_monitor.sv
// Checker for the primary link between bridge end and agent end.
// Assumes one sys_clk domain; sees resolved wires and drive enables.
`timescale 1ns/1ps
module pci_sig_monitor (
  // Clock, reset, grant
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        gnt_n,
  // Resolved wires
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe_n,
  input wire logic        par,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        trdy_n,
  input wire logic        devsel_n,
  // Drive enables
  input wire logic        dev_ad_oe,
  input wire logic        dev_cbe_oe,
  input wire logic        dev_par_oe,
  input wire logic        dev_frame_oe,
  input wire logic        dev_irdy_oe,
  input wire logic        agt_ad_oe,
  input wire logic        agt_par_oe,
  input wire logic        agt_trdy_oe
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rel(n, oe);
    oe && !n ##1 oe && n;
  endsequence
  sequence s_unclaimed;
    $fell(frame_n) ##1 devsel_n [*5];
  endsequence
  property p_par_dev;
    $past(dev_ad_oe) && dev_par_oe |-> par == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_par_dev: assert property (p_par_dev) else $error("bridge parity wrong");
  property p_par_agt;
    $past(agt_ad_oe) && agt_par_oe && !dev_par_oe |-> par == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_par_agt: assert property (p_par_agt) else $error("agent parity wrong");
  property p_park;
    !gnt_n && frame_n && irdy_n && !dev_frame_oe && !dev_irdy_oe |=> dev_ad_oe && dev_cbe_oe;
  endproperty
  a_park: assert property (p_park) else $error("idle bus not parked");
  property p_park_par;
    $rose(dev_ad_oe) ##1 dev_ad_oe |-> dev_par_oe;
  endproperty
  a_park_par: assert property (p_park_par) else $error("parity not driven");
  property p_par_rel;
    $fell(dev_ad_oe) |-> dev_par_oe ##1 !dev_par_oe;
  endproperty
  a_par_rel: assert property (p_par_rel) else $error("parity release late");
  property p_frame_rel;
    s_rel(frame_n, dev_frame_oe) |=> !dev_frame_oe;
  endproperty
  a_frame_rel: assert property (p_frame_rel) else $error("frame release wrong");
  property p_irdy_rel;
    s_rel(irdy_n, dev_irdy_oe) |=> !dev_irdy_oe;
  endproperty
  a_irdy_rel: assert property (p_irdy_rel) else $error("irdy release wrong");
  property p_trdy_rel;
    s_rel(trdy_n, agt_trdy_oe) |=> !agt_trdy_oe;
  endproperty
  a_trdy_rel: assert property (p_trdy_rel) else $error("trdy release wrong");
  property p_irdy_hold;
    !irdy_n && trdy_n && !devsel_n |=> !irdy_n;
  endproperty
  a_irdy_hold: assert property (p_irdy_hold) else $error("irdy dropped early");
  property p_trdy_data;
    !trdy_n && !dev_ad_oe |-> agt_ad_oe;
  endproperty
  a_trdy_data: assert property (p_trdy_data) else $error("trdy without data");
  property p_abort;
    s_unclaimed |-> ##[0:2] (frame_n && irdy_n);
  endproperty
  a_abort: assert property (p_abort) else $error("no master abort");
  property p_no_early;
    $fell(frame_n) ##1 devsel_n [*4] |-> !irdy_n;
  endproperty
  a_no_early: assert property (p_no_early) else $error("abort too early");
endmodule

// ### pci_primary_bus_signalling_bench.sv
// Bench joining bridge end and agent end over the primary link.
// Assumes the bridge user shows wdata/be_n for word_idx combinationally.
`timescale 1ns/1ps
module pci_primary_bus_signalling_bench;
  // ****
  // Signals
  // ****
  logic        sys_clk, rst_n, gnt_n, start, wr, dac, busy, rvalid, done, abort, perr;
  logic        sink_valid, agent_perr, got_abort, any_perr;
  logic [3:0]  cmd, be_n, sink_be_n, seen_cmd;
  logic [7:0]  count, word_idx, src_idx;
  logic [31:0] addr, wdata, rdata, src_data, sink_data, seen_addr;
  int          fails, check_count, words, last_cyc;

  // Word k carries its index so order slips show
  assign wdata    = 32'h5a00_0000 | {24'h0, word_idx};
  assign be_n     = word_idx[3:0] ^ 4'ha;
  assign src_data = 32'ha5a5_0000 | {24'h0, src_idx};

  pci_bus_if pci_bus_if_inst ();
  pci_bridge_end pci_bridge_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(pci_bus_if_inst.bridge), .gnt_n(gnt_n), .start(start), .wr(wr), .dac(dac),
    .cmd(cmd), .addr(addr), .addr_hi(32'h0000_0000), .count(count), .busy(busy),
    .wdata(wdata), .be_n(be_n), .word_idx(word_idx), .rdata(rdata), .rvalid(rvalid),
    .done(done), .abort(abort), .perr(perr));
  pci_agent_end pci_agent_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(pci_bus_if_inst.agent), .rdata(src_data), .word_idx(src_idx),
    .wdata(sink_data), .wbe_n(sink_be_n), .wvalid(sink_valid), .addr(seen_addr),
    .cmd(seen_cmd), .perr(agent_perr));
  pci_sig_monitor pci_sig_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n), .gnt_n(gnt_n),
    .ad(pci_bus_if_inst.ad), .cbe_n(pci_bus_if_inst.cbe_n), .par(pci_bus_if_inst.par),
    .frame_n(pci_bus_if_inst.frame_n), .irdy_n(pci_bus_if_inst.irdy_n),
    .trdy_n(pci_bus_if_inst.trdy_n), .devsel_n(pci_bus_if_inst.devsel_n),
    .dev_ad_oe(pci_bus_if_inst.dev_ad_oe), .dev_cbe_oe(pci_bus_if_inst.dev_cbe_oe),
    .dev_par_oe(pci_bus_if_inst.dev_par_oe), .dev_frame_oe(pci_bus_if_inst.dev_frame_oe),
    .dev_irdy_oe(pci_bus_if_inst.dev_irdy_oe), .agt_ad_oe(pci_bus_if_inst.agt_ad_oe),
    .agt_par_oe(pci_bus_if_inst.agt_par_oe), .agt_trdy_oe(pci_bus_if_inst.agt_trdy_oe));

  // ****
  // Helpers
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Runs one transfer; idle gap first so the take edge is the first one
  task automatic run_xfer(input logic w, input logic d, input logic [3:0] c,
                          input logic [31:0] a, input logic [7:0] n);
    int   ph;
    int   fin;
    logic pf;
    ph = -1;
    fin = -1;
    pf = 1'b1;
    words = 0;
    got_abort = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr = w;
    dac = d;
    cmd = c;
    addr = a;
    count = n;
    start = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(negedge sys_clk);
      if (busy === 1'b1) start = 1'b0;
      if (ph >= 0) ph++;
      if (pf === 1'b1 && pci_bus_if_inst.frame_n === 1'b0 && ph < 0) ph = 0;
      pf = pci_bus_if_inst.frame_n;
      if (ph == 0) check(pci_bus_if_inst.ad, a);
      if (ph == 0) check(32'(pci_bus_if_inst.cbe_n), 32'(d ? pci_sig_pkg::CMD_DAC : c));
      if (ph == 1 && d) check(32'(pci_bus_if_inst.cbe_n), 32'(c));
      if (sink_valid === 1'b1) begin
        check(sink_data, 32'h5a00_0000 | 32'(words));
        check(32'(sink_be_n), 32'(words[3:0] ^ 4'ha));
        words++;
      end
      if (rvalid === 1'b1) begin
        check(rdata, 32'ha5a5_0000 | 32'(words));
        words++;
      end
      if ((done === 1'b1 || abort === 1'b1) && fin < 0) begin
        fin = i;
        last_cyc = i;
        got_abort = abort;
      end
      if (fin >= 0 && i == fin + 3) break;
    end
    check(32'(fin >= 0), 32'h1);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_park();
    gnt_n = 1'b1;
    start = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(32'(busy), 32'h0);
    check(32'(pci_bus_if_inst.dev_ad_oe), 32'h0);
    start = 1'b0;
    gnt_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(32'(pci_bus_if_inst.dev_ad_oe & pci_bus_if_inst.dev_cbe_oe), 32'h1);
    check(32'(pci_bus_if_inst.dev_par_oe), 32'h1);
    check(32'(pci_bus_if_inst.par), 32'(^{pci_bus_if_inst.ad, pci_bus_if_inst.cbe_n}));
    $display("park test finished");
  endtask

  task automatic t_write_burst();
    run_xfer(1'b1, 1'b0, 4'h7, 32'h1000_0040, 8'h03);
    check(32'(words), 32'h3);
    check(seen_addr, 32'h1000_0040);
    check(32'(seen_cmd), 32'h7);
    check(32'(got_abort), 32'h0);
    $display("write burst test finished");
  endtask

  task automatic t_dac_read();
    run_xfer(1'b0, 1'b1, 4'h6, 32'h1234_5670, 8'h02);
    check(32'(words), 32'h2);
    check(32'(seen_cmd), 32'h6);
    check(seen_addr, 32'h1234_5670);
    $display("dual address read test finished");
  endtask

  task automatic t_abort();
    run_xfer(1'b1, 1'b0, 4'h7, 32'h2000_0000, 8'h01);
    check(32'(got_abort), 32'h1);
    check(32'(last_cyc), 32'h6);
    check(32'(words), 32'h0);
    check(32'(any_perr), 32'h0);
    $display("master abort test finished");
  endtask

  // ****
  // Run control
  // ****
  // Off the launch edge, so each one-cycle pulse is seen settled
  always @(negedge sys_clk) begin
    if (!rst_n) any_perr <= 1'b0;
    else if (perr === 1'b1 || agent_perr === 1'b1) any_perr <= 1'b1;
  end

  initial begin
    sys_clk = 1'b0;
    forever #(pci_sig_pkg::CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
  end

  // Tests need about 70 cycles; limit leaves wide margin
  initial begin
    #20000;
    fails++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    gnt_n = 1'b1;
    start = 1'b0;
    wr = 1'b0;
    dac = 1'b0;
    cmd = 4'h0;
    addr = 32'h0000_0000;
    count = 8'h01;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    t_park();
    t_write_burst();
    t_dac_read();
    t_abort();
    complete_run();
  end
endmodule
